// File: design/dac_waveform_player.v
`timescale 1ns/1ps
`include "wave_player_defines.vh"

module dac_waveform_player #(
  parameter ADDR_W = 16,
  parameter DEPTH = 65536
) (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire req_valid_i,
  input wire [7:0] req_code_i,
  input wire [7:0] req_value_lo_i,
  input wire [7:0] req_value_hi_i,
  input wire [7:0] req_index_lo_i,
  input wire [7:0] req_index_hi_i,
  output reg req_ready_o,
  input wire bulk_valid_i,
  input wire [15:0] bulk_data_i,
  output reg bulk_ready_o,
  input wire ext_trigger_i,
  input wire loop_in_i,
  output reg ref_enable_o,
  output reg led_active_o,
  output reg running_o,
  output reg [7:0] dac_load_o,
  output reg [11:0] dac_value_o,
  output reg frame_mark_o,
  output reg channel_restart_o,
  output reg end_of_waveform_flag_o,
  output reg play_sram_o
);

  // Two memories; the role bit write_sram_r selects the half, not the address
  reg [15:0] mem_lo [0:DEPTH-1];
  reg [15:0] mem_hi [0:DEPTH-1];

  reg [ADDR_W-1:0] wr_ptr_r;
  reg [ADDR_W-1:0] play_ptr_r;
  reg write_sram_r;
  reg wr_armed_r;
  reg [15:0] rate_r;
  reg [15:0] rate_cnt_r;
  reg [2:0] chan_r;
  reg swap_wait_r;
  reg [15:0] rd_word_r;
  reg rd_pend_r;
  reg trig_d_r;

  // Two-entry skid buffer between the bulk endpoint and the memory port
  reg [15:0] buf_data_r [0:1];
  reg [1:0] buf_cnt_r;
  reg buf_rd_r;
  reg buf_wr_r;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [15:0] buf_out_data;
  wire mem_ready;
  wire bulk_take;
  wire buf_pop;

  wire req_control;
  wire req_location;
  wire req_rate;
  wire req_swapwait;
  wire cmd_reset;
  wire cmd_run;
  wire [15:0] index_field;
  wire [15:0] value_field;
  wire [15:0] loc_sum;
  wire rate_tick;
  wire play_fetch;
  wire swap_now;
  wire bank_valid;
  wire [18:0] bank_base;
  wire [18:0] loc_full;

  // Setup bytes assemble into value and index fields
  assign value_field = {req_value_hi_i, req_value_lo_i};
  assign index_field = {req_index_hi_i, req_index_lo_i};

  // Request decode; B3 and B5 are accepted and ignored
  assign req_control = req_valid_i && (req_code_i == `REQ_CONTROL_COMMAND);
  assign req_location = req_valid_i && (req_code_i == `REQ_WRITE_LOCATION);
  assign req_rate = req_valid_i && (req_code_i == `REQ_RATE_DIVISOR);
  assign req_swapwait = req_valid_i && (req_code_i == `REQ_SWAP_WAIT) && req_ready_o;
  assign cmd_reset = req_control && value_field[`CMD_RESET_BIT];
  // Pause bit reserved: no logic reads it
  assign cmd_run = req_control && value_field[`CMD_RUN_BIT] && !cmd_reset;

  // Bank times bank size plus offset gives the flat location.
  // The product is formed at full width and cut on purpose, so an offset
  // that runs past the bank end simply lands further up the flat space.
  assign bank_valid = (value_field[15:8] <= {5'h00, `BANK_LAST});
  assign bank_base = value_field[10:8] * `BANK_SIZE;
  assign loc_full = bank_base + {3'b000, index_field};
  // A bank number above seven leaves the write pointer where it was
  assign loc_sum = bank_valid ? loc_full[15:0] : wr_ptr_r;

  // Skid buffer occupancy and flags
  assign buf_in_ready = (buf_cnt_r != 2'd2);
  assign buf_out_valid = (buf_cnt_r != 2'd0);
  assign buf_out_data = buf_data_r[buf_rd_r];
  // Memory accepts only once the write pointer is placed and no reset is pending
  assign mem_ready = wr_armed_r && !cmd_reset && !req_location;
  assign buf_pop = buf_out_valid && mem_ready;
  assign bulk_take = bulk_valid_i && bulk_ready_o;
  assign swap_now = buf_pop && (wr_ptr_r == `BUFFER_LAST);

  // A trigger edge and a counter expiry in one cycle give a single tick,
  // so the host cannot get two words out of one period that way.
  // The trigger is only edge detected; a pin held high ticks once.
  // The edge register idles low, matching the idle level of the pin.
  // Rate divisor: external trigger also counts, as a second source of ticks
  assign rate_tick = running_o &&
                     ((rate_cnt_r == 16'h0000) || (ext_trigger_i && !trig_d_r));
  assign play_fetch = rate_tick && !rd_pend_r;

  // Skid buffer storage
  always @(posedge sys_clk_i) begin
    if (bulk_take) begin
      buf_data_r[buf_wr_r] <= bulk_data_i;
    end
  end

  // Ready is registered to keep the endpoint path short, so it is worked
  // out one cycle ahead from the occupancy that the next edge will leave.
  // Two entries are enough for that: one word may arrive while ready falls.
  // A reset command empties the buffer, dropping words not yet stored.
  // Skid buffer pointers; stall propagates back to the endpoint via ready
  always @(posedge sys_clk_i) begin
    if (!rstn_i || cmd_reset) begin
      buf_cnt_r <= 2'd0;
      buf_rd_r <= 1'b0;
      buf_wr_r <= 1'b0;
      bulk_ready_o <= 1'b0;
    end else begin
      if (bulk_take) begin
        buf_wr_r <= ~buf_wr_r;
      end
      if (buf_pop) begin
        buf_rd_r <= ~buf_rd_r;
      end
      case ({bulk_take, buf_pop})
        2'b10: buf_cnt_r <= buf_cnt_r + 2'd1;
        2'b01: buf_cnt_r <= buf_cnt_r - 2'd1;
        default: buf_cnt_r <= buf_cnt_r;
      endcase
      // Registered ready: only assert when an entry stays free next cycle
      bulk_ready_o <= (buf_cnt_r == 2'd0) ||
                      (buf_cnt_r == 2'd1 && (buf_pop || !bulk_take)) ||
                      (buf_cnt_r == 2'd2 && buf_pop && !bulk_take);
    end
  end

  // The role bit picks the memory, so the write side can only ever touch
  // the half that is not playing; no address compare is needed for that.
  // A word landing on the last location is still stored before the swap.
  // Writes are lost only when a reset command or the reset pin empties the buffer, never by a stall.
  // Write port into the write memory, never the play memory
  always @(posedge sys_clk_i) begin
    if (buf_pop) begin
      if (write_sram_r) begin
        mem_hi[wr_ptr_r] <= buf_out_data;
      end else begin
        mem_lo[wr_ptr_r] <= buf_out_data;
      end
    end
  end

  // One registered read per tick; the word is applied one edge later,
  // which is why playback outputs trail the tick by two cycles.
  // The pending flag blocks a second fetch while a word is in flight.
  // Read port of the play memory
  always @(posedge sys_clk_i) begin
    if (play_fetch) begin
      rd_word_r <= write_sram_r ? mem_lo[play_ptr_r] : mem_hi[play_ptr_r];
    end
  end

  // The pointer wraps from the last location to zero as the roles swap,
  // so a long stream keeps filling the halves in turn.
  // A location request in the same cycle as a pop wins; the pop waits.
  // Reset points writes at memory one, leaving memory zero to play.
  // Write pointer and memory roles
  always @(posedge sys_clk_i) begin
    if (!rstn_i || cmd_reset) begin
      wr_ptr_r <= {ADDR_W{1'b0}};
      write_sram_r <= 1'b1;
      wr_armed_r <= 1'b0;
    end else if (req_location) begin
      wr_ptr_r <= loc_sum;
      wr_armed_r <= 1'b1;
    end else if (buf_pop) begin
      wr_ptr_r <= wr_ptr_r + 16'h0001;
      if (swap_now) begin
        write_sram_r <= ~write_sram_r;
      end
    end
  end

  // A swap that lands in the same cycle as a new swap-wait request is not
  // counted for it; the request then waits for the following swap.
  // A second swap-wait while one is pending is refused by the ready term.
  // Other requests are still decoded while ready is low.
  // Control request handshake: swap-wait holds ready low until a swap
  always @(posedge sys_clk_i) begin
    if (!rstn_i || cmd_reset) begin
      req_ready_o <= 1'b1;
      swap_wait_r <= 1'b0;
    end else if (req_swapwait) begin
      req_ready_o <= 1'b0;
      swap_wait_r <= 1'b1;
    end else if (swap_wait_r && swap_now) begin
      req_ready_o <= 1'b1;
      swap_wait_r <= 1'b0;
    end
  end

  // The period is the divisor plus one cycle; a divisor of zero or one
  // still plays only every other cycle, limited by the fetch pipeline.
  // The divisor survives a reset command; only the reset pin restores it.
  // While stopped the counter is kept loaded so the first word is on time.
  // Rate divisor register and down counter
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rate_r <= `RATE_RESET;
      rate_cnt_r <= `RATE_RESET;
      trig_d_r <= 1'b0;
    end else begin
      trig_d_r <= ext_trigger_i;
      if (req_rate) begin
        rate_r <= index_field;
        rate_cnt_r <= index_field;
      end else if (!running_o || rate_tick) begin
        rate_cnt_r <= rate_r;
      end else begin
        rate_cnt_r <= rate_cnt_r - 16'h0001;
      end
    end
  end

  // An end word clears running in the same edge that shows it, so no
  // further tick can fetch past it; run clears the end flag again.
  // The channel counter wraps after seven even with no restart flag,
  // though hosts are expected to mark the last channel they use.
  // Playback control, play pointer and channel routing
  always @(posedge sys_clk_i) begin
    if (!rstn_i || cmd_reset) begin
      running_o <= 1'b0;
      ref_enable_o <= 1'b0;
      led_active_o <= 1'b0;
      play_ptr_r <= {ADDR_W{1'b0}};
      chan_r <= 3'h0;
      rd_pend_r <= 1'b0;
      dac_load_o <= 8'h00;
      dac_value_o <= 12'h000;
      frame_mark_o <= 1'b0;
      channel_restart_o <= 1'b0;
      end_of_waveform_flag_o <= 1'b0;
    end else begin
      dac_load_o <= 8'h00;
      channel_restart_o <= 1'b0;
      frame_mark_o <= 1'b0;
      rd_pend_r <= play_fetch;
      if (cmd_run) begin
        ref_enable_o <= 1'b1;
        running_o <= 1'b1;
        led_active_o <= 1'b1;
        end_of_waveform_flag_o <= 1'b0;
      end
      if (play_fetch) begin
        play_ptr_r <= play_ptr_r + 16'h0001;
      end
      if (rd_pend_r) begin
        // Word just fetched is applied to the current channel
        dac_value_o <= rd_word_r[`WORD_VALUE_MSB:0];
        dac_load_o <= 8'h01 << chan_r;
        frame_mark_o <= rd_word_r[`WORD_FRAME_BIT];
        if (rd_word_r[`WORD_RESTART_BIT] || chan_r == `CHAN_LAST) begin
          chan_r <= 3'h0;
          channel_restart_o <= 1'b1;
        end else begin
          chan_r <= chan_r + 3'h1;
        end
        if (rd_word_r[`WORD_END_BIT]) begin
          running_o <= 1'b0;
          end_of_waveform_flag_o <= 1'b1;
        end
        if (rd_word_r[`WORD_LOOP_BIT]) begin
          play_ptr_r <= {ADDR_W{1'b0}};
        end
      end
      // External loop pin wins over the pointer advance
      if (loop_in_i) begin
        play_ptr_r <= {ADDR_W{1'b0}};
      end
    end
  end

  // Follows the role bit one edge later; a reset command forces it to the
  // reset roles at once so status never shows the old half after a reset.
  // Which memory is playing, exported for status
  always @(posedge sys_clk_i) begin
    if (!rstn_i || cmd_reset) begin
      play_sram_o <= 1'b0;
    end else begin
      play_sram_o <= ~write_sram_r;
    end
  end

endmodule

// File: design/wave_player_defines.vh
`ifndef WAVE_PLAYER_DEFINES_VH
`define WAVE_PLAYER_DEFINES_VH
// Vendor request codes
`define REQ_CONTROL_COMMAND 8'hb0
`define REQ_WRITE_LOCATION 8'hb1
`define REQ_RATE_DIVISOR 8'hb2
`define REQ_RESERVED_B3 8'hb3
`define REQ_SWAP_WAIT 8'hb4
`define REQ_RESERVED_B5 8'hb5
// Command byte bits
`define CMD_RESET_BIT 7
`define CMD_PAUSE_BIT 6
`define CMD_RUN_BIT 0
// Waveform word fields
`define WORD_END_BIT 15
`define WORD_FRAME_BIT 14
`define WORD_RESTART_BIT 13
`define WORD_LOOP_BIT 12
`define WORD_VALUE_MSB 11
// Memory layout
`define BANK_SIZE 16'h1fff
`define BUFFER_LAST 16'hffff
`define BANK_LAST 3'h7
// Reset value and last channel
`define RATE_RESET 16'h0190
`define CHAN_LAST 3'h7
`endif

// File: sim/dac_waveform_player_assertions.sv
`timescale 1ns/1ps
`include "wave_player_defines.vh"
// Port checks of request decode and playback strobes
module dac_waveform_player_checker (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire req_valid_i,
  input wire [7:0] req_code_i,
  input wire [7:0] req_value_lo_i,
  input wire req_ready_o,
  input wire ref_enable_o,
  input wire led_active_o,
  input wire running_o,
  input wire [7:0] dac_load_o,
  input wire frame_mark_o,
  input wire end_of_waveform_flag_o,
  input wire play_sram_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // Control command seen this edge
  wire cmd_w = req_valid_i && req_code_i == `REQ_CONTROL_COMMAND;
  AST_WAIT_STALLS: assert property (req_valid_i && req_ready_o &&
    req_code_i == `REQ_SWAP_WAIT |=> !req_ready_o) else $error("swap wait kept ready");
  AST_RUN_STARTS: assert property (cmd_w && req_value_lo_i[0] &&
    !req_value_lo_i[7] |=> running_o && ref_enable_o) else $error("run not started");
  AST_RESET_CMD: assert property (cmd_w && req_value_lo_i[7] |=>
    !running_o && !ref_enable_o && !led_active_o && !play_sram_o) else $error("reset cmd");
  AST_ONE_CHANNEL: assert property ($onehot0(dac_load_o)) else $error("two strobes");
  AST_FRAME_WITH_WORD: assert property (frame_mark_o |-> dac_load_o != 8'h00)
    else $error("frame without word");
  AST_END_HALTS: assert property ($rose(end_of_waveform_flag_o) |-> ##[0:1] !running_o)
    else $error("end word did not halt");
  AST_LOAD_WHEN_RUN: assert property (dac_load_o != 8'h00 |-> $past(running_o, 2))
    else $error("strobe while stopped");
  AST_RESET_ROLES: assert property ($rose(rstn_i) |-> req_ready_o && !running_o &&
    !play_sram_o) else $error("reset state");
  cover property (frame_mark_o);
  cover property ($rose(end_of_waveform_flag_o));
  cover property (!req_ready_o ##1 req_ready_o);
endmodule
bind dac_waveform_player dac_waveform_player_checker u_chk (.sys_clk_i(sys_clk_i),
  .rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_code_i(req_code_i),
  .req_value_lo_i(req_value_lo_i), .req_ready_o(req_ready_o), .ref_enable_o(ref_enable_o),
  .led_active_o(led_active_o), .running_o(running_o), .dac_load_o(dac_load_o),
  .frame_mark_o(frame_mark_o), .end_of_waveform_flag_o(end_of_waveform_flag_o),
  .play_sram_o(play_sram_o));

// File: sim/host_model.sv
`timescale 1ns/1ps
// Host side: control requests and bulk words
module host_model (
  input wire sys_clk_i,
  input wire bulk_ready_i,
  output reg req_valid_o,
  output reg [7:0] req_code_o,
  output reg [7:0] value_lo_o,
  output reg [7:0] value_hi_o,
  output reg [15:0] index_o,
  output reg bulk_valid_o,
  output reg [15:0] bulk_data_o,
  output reg ext_trigger_o,
  output reg loop_in_o
);
  initial begin
    {req_valid_o, req_code_o, value_lo_o, value_hi_o, index_o} = 41'h0;
    {bulk_valid_o, bulk_data_o, ext_trigger_o, loop_in_o} = 19'h0;
  end
  // One-cycle request; released fields are inverted so stale values never match
  task send_req(input [7:0] code, input [7:0] vhi, input [7:0] vlo, input [15:0] idx);
    begin
      @(posedge sys_clk_i);
      #1 {req_code_o, value_hi_o, value_lo_o, index_o} = {code, vhi, vlo, idx};
      req_valid_o = 1'b1;
      @(posedge sys_clk_i);
      #1 {req_code_o, value_hi_o, value_lo_o, index_o} = ~{code, vhi, vlo, idx};
      req_valid_o = 1'b0;
    end
  endtask
  // Word held until an edge sees ready high; bounded so a stall cannot hang the host
  task send_word(input [15:0] w, output bit ok);
    integer n;
    begin
      @(posedge sys_clk_i);
      #1 {bulk_valid_o, bulk_data_o} = {1'b1, w};
      n = 0;
      while (bulk_ready_i !== 1'b1 && n < 20) begin
        @(posedge sys_clk_i);
        #1 n++;
      end
      ok = (n < 20);
      @(posedge sys_clk_i);
      #1 {bulk_valid_o, bulk_data_o} = {1'b0, ~w};
    end
  endtask
  // Trigger and loop pins, changed just after an edge
  task set_pins(input trig, input lp);
    begin
      @(posedge sys_clk_i);
      #1 ext_trigger_o = trig;
      loop_in_o = lp;
    end
  endtask
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ps
`include "wave_player_defines.vh"
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module testbench;
  reg sys_clk_i = 1'b0;
  reg rstn_i = 1'b0;
  wire req_valid, bulk_valid, ext_trig, loop_in, req_ready, bulk_ready;
  wire ref_en, led, running, frame, restart, end_flag, play_sram;
  wire [7:0] code, vlo, vhi, dac_load;
  wire [15:0] idx, bulk_data;
  wire [11:0] dac_value;
  integer n_fail = 0;
  integer n_tests = 0;
  bit ok;
  reg seen;
  // 40 ns period
  always #20 sys_clk_i = ~sys_clk_i;
  host_model u_host (.sys_clk_i(sys_clk_i), .bulk_ready_i(bulk_ready), .req_valid_o(req_valid),
    .req_code_o(code), .value_lo_o(vlo), .value_hi_o(vhi), .index_o(idx),
    .bulk_valid_o(bulk_valid), .bulk_data_o(bulk_data), .ext_trigger_o(ext_trig),
    .loop_in_o(loop_in));
  dac_waveform_player u_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid),
    .req_code_i(code), .req_value_lo_i(vlo), .req_value_hi_i(vhi), .req_index_lo_i(idx[7:0]),
    .req_index_hi_i(idx[15:8]), .req_ready_o(req_ready), .bulk_valid_i(bulk_valid),
    .bulk_data_i(bulk_data), .bulk_ready_o(bulk_ready), .ext_trigger_i(ext_trig),
    .loop_in_i(loop_in), .ref_enable_o(ref_en), .led_active_o(led), .running_o(running),
    .dac_load_o(dac_load), .dac_value_o(dac_value), .frame_mark_o(frame),
    .channel_restart_o(restart), .end_of_waveform_flag_o(end_flag), .play_sram_o(play_sram));
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // No location loaded: buffer takes two words then refuses; then pulse the reset pin
  task t_stall;
    begin
      repeat (3) u_host.send_word(16'h0aaa, ok);
      `CHK("bulk_ready", 1'b0, bulk_ready)
      `CHK("third word", 1'b0, ok)
      rstn_i = 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1 rstn_i = 1'b1;
    end
  endtask
  // Reserved codes and the pause bit leave playback idle
  task t_idle;
    begin
      `CHK("play_sram", 1'b0, play_sram)
      u_host.send_req(`REQ_RESERVED_B3, 8'h00, 8'h01, 16'h0000);
      u_host.send_req(`REQ_RESERVED_B5, 8'h00, 8'h01, 16'h0000);
      u_host.send_req(`REQ_CONTROL_COMMAND, 8'h00, 8'h40, 16'h0000);
      `CHK("running", 1'b0, running)
      `CHK("ref_en", 1'b0, ref_en)
    end
  endtask
  // Load three tagged words, swap by the last location, run at divisor 4
  task t_play;
    reg [15:0] w [0:2];
    integer i, n;
    begin
      w[0] = 16'h4123;
      w[1] = 16'h2456;
      w[2] = 16'h8789;
      u_host.send_req(`REQ_RATE_DIVISOR, 8'h00, 8'h00, 16'h0004);
      u_host.send_req(`REQ_WRITE_LOCATION, 8'h00, 8'h00, 16'h0000);
      for (i = 0; i < 3; i++) u_host.send_word(w[i], ok);
      // Bank 7 plus 0x2006 is the final buffer location
      u_host.send_req(`REQ_WRITE_LOCATION, 8'h07, 8'h00, 16'h2006);
      u_host.send_req(`REQ_SWAP_WAIT, 8'h00, 8'h00, 16'h0000);
      `CHK("wait stall", 1'b0, req_ready)
      u_host.send_word(16'h0000, ok);
      n = 0;
      while (req_ready !== 1'b1 && n < 20) begin
        @(posedge sys_clk_i);
        #1 n++;
      end
      `CHK("wait release", 1'b1, req_ready)
      // Status follows the role bit one edge later
      @(posedge sys_clk_i);
      #1;
      `CHK("play_sram", 1'b1, play_sram)
      u_host.send_req(`REQ_CONTROL_COMMAND, 8'h00, 8'h01, 16'h0000);
      `CHK("ref_en", 1'b1, ref_en)
      seen = 1'b0;
      for (i = 0; i < 3; i++) begin
        n = 0;
        do begin
          @(posedge sys_clk_i);
          #1 n++;
          seen = seen | restart;
        end while (dac_load == 8'h00 && n < 60);
        if (i > 0) `CHK("period", 5, n)
        `CHK("channel", (i == 1) ? 8'h02 : 8'h01, dac_load)
        `CHK("value", w[i][11:0], dac_value)
        `CHK("frame", (i == 0), frame)
      end
      repeat (3) begin
        @(posedge sys_clk_i);
        #1 seen = seen | restart;
      end
      `CHK("restart pulse", 1'b1, seen)
      `CHK("running", 1'b0, running)
      `CHK("end flag", 1'b1, end_flag)
    end
  endtask
  // Loop pin holds the pointer at zero; a trigger edge forces an early fetch
  task t_pins;
    integer n;
    begin
      u_host.send_req(`REQ_RATE_DIVISOR, 8'h00, 8'h00, 16'h0100);
      u_host.set_pins(1'b0, 1'b1);
      u_host.send_req(`REQ_CONTROL_COMMAND, 8'h00, 8'h01, 16'h0000);
      `CHK("end flag cleared", 1'b0, end_flag)
      `CHK("running again", 1'b1, running)
      u_host.set_pins(1'b1, 1'b1);
      u_host.set_pins(1'b0, 1'b1);
      n = 0;
      while (dac_load == 8'h00 && n < 8) begin
        @(posedge sys_clk_i);
        #1 n++;
      end
      `CHK("trigger fetch", 8'h02, dac_load)
      `CHK("loop value", 12'h123, dac_value)
      u_host.set_pins(1'b0, 1'b0);
    end
  endtask
  // Reset command restores roles and darkens outputs
  task t_cmd_reset;
    begin
      u_host.send_req(`REQ_CONTROL_COMMAND, 8'h00, 8'h80, 16'h0000);
      `CHK("ref_en", 1'b0, ref_en)
      `CHK("led", 1'b0, led)
      `CHK("play_sram", 1'b0, play_sram)
    end
  endtask
  // Whole run is under a thousand cycles
  initial begin
    #(40 * 5000);
    n_fail++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    #1 rstn_i = 1'b1;
    t_stall;
    t_idle;
    t_play;
    t_pins;
    t_cmd_reset;
    wrap_up;
  end
endmodule
